// [sac_afe_model.sv]
`timescale 1ns/10ps
module sac_afe_model
  import sac_pkg::*;
(
  input wire logic core_clk,
  input wire sac_pkg::sac_afe_t afe,
  output logic cmp_above
);
  logic flip_q = 1'b0;
  always_ff @(posedge core_clk) begin
    flip_q <= ~flip_q;
  end
  // Each channel level sits half a step above code {channel, 5, channel bit 0}, so ties never arise.
  // Even channels end in a zero, so a final decision of zero must reach the result as well.
  // Unpowered, the comparator gives noise, so a stale decision cannot pass for a good one.
  always_comb begin
    if (afe.powered) begin
      cmp_above = ({afe.channel, 4'h5, afe.channel[0]} >= afe.trial);
    end else begin
      cmp_above = flip_q;
    end
  end
endmodule

// [sac_chk.sv]
`timescale 1ns/10ps
module sac_chk
  import sac_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [9:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic [5:0] port_a_oe,
  input wire logic sleep_active,
  input wire logic [3:0] ccp_mode,
  input wire logic ccp_event,
  input wire sac_pkg::sac_afe_t afe,
  input wire logic timer_clear,
  input wire logic wake_req
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_ack;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  sequence s_rd(idx);
    s_req ##0 !wb_we_i && wb_adr_i[9:2] == idx;
  endsequence
  AST_ACK: assert property (s_req |=> s_ack)
    else $error("ack missing or longer than one cycle");
  AST_DAT_HI: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h000000)
    else $error("read data upper bits not zero");
  AST_UNMAPPED: assert property (s_rd(8'h00) |=> wb_dat_o == 32'h00000000)
    else $error("unmapped read not zero");
  AST_CTRL_RSVD: assert property (s_rd(IDX_CTRL) |=> !wb_dat_o[1])
    else $error("control bit 1 reads one");
  AST_PINCFG_RSVD: assert property (s_rd(IDX_PINCFG) |=> wb_dat_o[7:3] == 5'h00)
    else $error("pin config upper bits not zero");
  AST_TCLR_SET: assert property (ccp_event && ccp_mode == CMP_MODE_TRIG |=> timer_clear)
    else $error("timer clear missing after trigger");
  AST_TCLR_CAUSE: assert property (timer_clear |-> $past(ccp_event && ccp_mode == CMP_MODE_TRIG))
    else $error("timer clear without trigger");
  AST_RST: assert property ($rose(reset_n) |-> !afe.powered && port_a_oe == 6'h00)
    else $error("reset state wrong");
  AST_WAKE: assert property (wake_req |-> $past(sleep_active) ##1 !wake_req)
    else $error("wake request outside sleep or too long");
endmodule

bind sac_ctrl sac_chk sac_chk_inst (.core_clk, .reset_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
  .wb_dat_o, .wb_ack_o, .port_a_oe, .sleep_active, .ccp_mode, .ccp_event, .afe, .timer_clear, .wake_req);

// [sac_ctrl.sv]
`timescale 1ns/10ps
module sac_ctrl
  import sac_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic por_event,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [9:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [5:0] port_a_in,
  output logic [5:0] port_a_out,
  output logic [5:0] port_a_oe,
  input wire logic [2:0] port_e_in,
  output logic [2:0] port_e_out,
  output logic [2:0] port_e_oe,
  output logic vref_from_pin,
  input wire logic sleep_active,
  input wire logic cmp_above,
  input wire logic [3:0] ccp_mode,
  input wire logic ccp_event,
  output sac_pkg::sac_afe_t afe,
  output logic timer_clear,
  output logic wake_req
);
  import sac_pkg::*;

  logic ack_q;
  logic [7:0] dat_q;
  logic [1:0] cs_q;
  logic [2:0] ch_q;
  logic go_q;
  logic on_q;
  logic [2:0] pcfg_q;
  logic [5:0] dir_a_q;
  logic [2:0] dir_e_q;
  logic [7:4] dir_e_hi_q;
  logic [5:0] lat_a_q;
  logic [2:0] lat_e_q;
  logic [7:0] intctl_q;
  logic [7:0] pflag1_q;
  logic [7:0] pen1_q;
  logic pflag2_q;
  logic pen2_q;
  logic [7:0] result_q;
  logic [7:0] trial_q;
  logic [4:0] hc_q;
  logic [2:0] hold_q;
  logic [8:0] div_q;
  logic [2:0] dly_q;
  logic down_q;
  logic sleep_q;
  logic timer_clear_q;
  logic wake_q;
  sac_state_t state_q;

  logic bus_go;
  logic wr;
  logic [7:0] idx;
  logic [7:0] wd;
  logic [7:0] rd;
  logic [7:0] analog;
  logic [8:0] div_lim;
  logic half;
  logic div_clr;
  logic [5:0] mask_a;
  logic trig;
  logic sw_start;
  logic sw_stop;
  logic conv_end;
  logic sleep_abort;
  logic running;
  logic [2:0] bit_idx;

  assign bus_go = wb_cyc_i && wb_stb_i && !ack_q;
  assign wr = bus_go && wb_we_i && wb_sel_i[0];
  assign idx = wb_adr_i[9:2];
  assign wd = wb_dat_i[7:0];
  assign running = (state_q == ST_CONV) || (state_q == ST_DELAY);

  // Analogue pin map, bit order RA0 RA1 RA2 RA3 RA5 RE0 RE1 RE2.
  always_comb begin
    case (pcfg_q)
      3'h0, 3'h1: analog = 8'hFF;
      3'h2, 3'h3: analog = 8'h1F;
      3'h4, 3'h5: analog = 8'h0B;
      default: analog = 8'h00;
    endcase
    // A pin that carries the reference is not an analogue input, so it reads as a digital pin.
    if (pcfg_q[0]) begin
      analog[3] = 1'b0;
    end
  end

  assign vref_from_pin = pcfg_q[0] && (pcfg_q[2:1] != 2'h3);

  // Half bit period divider; the RC period is modelled from the core clock.
  always_comb begin
    case (cs_q)
      CS_DIV2: div_lim = 9'h001;
      CS_DIV8: div_lim = 9'h004;
      CS_DIV32: div_lim = 9'h010;
      default: div_lim = 9'(RC_HALF_CYC);
    endcase
  end

  // Greater-or-equal lets a clock select change mid-count end the period at once rather than wrap.
  assign half = (div_q >= div_lim - 9'h001);
  // An abort restarts the count, so the hold that follows lasts two whole bit periods.
  assign div_clr = !(state_q == ST_CONV || state_q == ST_HOLD) || half || (running && sw_stop);

  always_ff @(posedge core_clk) begin
    if (!reset_n || div_clr) begin
      div_q <= 9'h000;
    end else begin
      div_q <= div_q + 9'h001;
    end
  end

  assign trig = ccp_event && (ccp_mode == CMP_MODE_TRIG);
  // The old on bit gates the start, so a write that turns on and starts at once is ignored.
  assign sw_start = wr && (idx == IDX_CTRL) && wd[CTRL_GO] && on_q;
  assign sw_stop = wr && (idx == IDX_CTRL) && !wd[CTRL_GO];
  assign conv_end = (state_q == ST_CONV) && half && (hc_q == HC_DONE);
  assign sleep_abort = sleep_active && !sleep_q && (cs_q != CS_RC) && on_q;
  assign bit_idx = 3'h7 - hc_q[3:1];

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      sleep_q <= 1'b0;
      timer_clear_q <= 1'b0;
    end else begin
      sleep_q <= sleep_active;
      timer_clear_q <= trig;
    end
  end

  // Start and abort sequencing.
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      state_q <= ST_OFF;
      go_q <= 1'b0;
      down_q <= 1'b0;
      hc_q <= 5'h00;
      hold_q <= 3'h0;
      dly_q <= 3'h0;
      trial_q <= 8'h00;
    end else begin
      // Power-down lasts until the core leaves sleep; the on bit stays as software wrote it.
      if (!sleep_active) begin
        down_q <= 1'b0;
      end
      case (state_q)
        ST_OFF: begin
          go_q <= 1'b0;
          if (on_q && !down_q) begin
            state_q <= ST_ACQ;
          end
        end
        ST_ACQ: begin
          if (sw_start || (trig && on_q)) begin
            go_q <= 1'b1;
            trial_q <= SAR_MSB;
            hc_q <= 5'h00;
            dly_q <= 3'h0;
            state_q <= (cs_q == CS_RC) ? ST_DELAY : ST_CONV;
          end
        end
        ST_DELAY: begin
          dly_q <= dly_q + 3'h1;
          if (dly_q == 3'(INST_CYC - 1)) begin
            state_q <= ST_CONV;
          end
        end
        ST_CONV: begin
          if (half) begin
            hc_q <= hc_q + 5'h01;
            if (hc_q[0] && hc_q < 5'h10) begin
              trial_q[bit_idx] <= cmp_above;
              if (bit_idx != 3'h0) begin
                trial_q[bit_idx - 3'h1] <= 1'b1;
              end
            end
          end
          if (conv_end) begin
            go_q <= 1'b0;
            hold_q <= 3'h0;
            state_q <= ST_HOLD;
            if (sleep_active && !pen1_q[DONE_BIT]) begin
              down_q <= 1'b1;
            end
          end
        end
        // Four half periods make the two bit periods that must pass before sampling again.
        ST_HOLD: begin
          if (half) begin
            hold_q <= hold_q + 3'h1;
            if (hold_q == HOLD_HALVES - 3'h1) begin
              state_q <= ST_ACQ;
            end
          end
        end
        default: state_q <= ST_OFF;
      endcase
      if (running && sw_stop && !conv_end) begin
        go_q <= 1'b0;
        hold_q <= 3'h0;
        state_q <= ST_HOLD;
      end
      if (sleep_abort) begin
        go_q <= 1'b0;
        down_q <= 1'b1;
        state_q <= ST_OFF;
      end
      if (!on_q || down_q) begin
        go_q <= 1'b0;
        state_q <= ST_OFF;
      end
    end
  end

  // Done flag and wake request; a hardware set beats a software clear.
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      pflag1_q <= 8'h00;
      wake_q <= 1'b0;
    end else begin
      if (wr && idx == IDX_PFLAG1) begin
        pflag1_q <= wd;
      end
      if (conv_end) begin
        pflag1_q[DONE_BIT] <= 1'b1;
      end
      wake_q <= conv_end && sleep_active && pen1_q[DONE_BIT];
    end
  end

  // Result survives ordinary resets; only power-on or brown-out clears it.
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      if (por_event) begin
        result_q <= RESULT_POR;
      end
    end else if (conv_end) begin
      // The last decision already sits in the trial register when the count ends.
      result_q <= trial_q;
    end else if (wr && idx == IDX_RESULT) begin
      result_q <= wd;
    end
  end

  // Software controls.
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      cs_q <= CTRL_RST[7:6];
      ch_q <= CTRL_RST[5:3];
      on_q <= CTRL_RST[0];
      pcfg_q <= PINCFG_RST;
      dir_a_q <= DIR_A_RST;
      dir_e_q <= DIR_E_RST[2:0];
      dir_e_hi_q <= DIR_E_RST[7:4];
      lat_a_q <= 6'h00;
      lat_e_q <= 3'h0;
      intctl_q <= 8'h00;
      pen1_q <= 8'h00;
      pflag2_q <= 1'b0;
      pen2_q <= 1'b0;
    end else if (wr) begin
      case (idx)
        IDX_CTRL: begin
          cs_q <= wd[CTRL_CS_LO +: 2];
          ch_q <= wd[CTRL_CH_LO +: 3];
          on_q <= wd[CTRL_ON];
        end
        IDX_PINCFG: pcfg_q <= wd[2:0];
        IDX_DIR_A: dir_a_q <= wd[5:0];
        IDX_DIR_E: begin
          dir_e_q <= wd[2:0];
          dir_e_hi_q <= wd[7:4];
        end
        IDX_PORT_A: lat_a_q <= wd[5:0];
        IDX_PORT_E: lat_e_q <= wd[2:0];
        IDX_INTCTL, IDX_INTCTL_HI: intctl_q <= wd;
        IDX_PEN1: pen1_q <= wd;
        IDX_PFLAG2: pflag2_q <= wd[0];
        IDX_PEN2: pen2_q <= wd[0];
        default: begin
        end
      endcase
    end
  end

  // RA4 has no analogue function, so its mask bit is always clear.
  assign mask_a = {analog[4], 1'b0, analog[3:0]};

  // Read mux; digital reads of analogue pins return zero.
  always_comb begin
    case (idx)
      IDX_PORT_A: rd = {2'h0, port_a_in & ~mask_a};
      IDX_PORT_E: rd = {5'h00, port_e_in & ~analog[7:5]};
      IDX_INTCTL, IDX_INTCTL_HI: rd = intctl_q;
      IDX_PFLAG1: rd = pflag1_q;
      IDX_PFLAG2: rd = {7'h00, pflag2_q};
      IDX_RESULT: rd = result_q;
      IDX_CTRL: rd = {cs_q, ch_q, go_q, 1'b0, on_q};
      IDX_DIR_A: rd = {2'h0, dir_a_q};
      IDX_DIR_E: rd = {dir_e_hi_q, 1'b0, dir_e_q};
      IDX_PEN1: rd = pen1_q;
      IDX_PEN2: rd = {7'h00, pen2_q};
      IDX_PINCFG: rd = {5'h00, pcfg_q};
      default: rd = 8'h00;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      ack_q <= 1'b0;
      dat_q <= 8'h00;
    end else begin
      ack_q <= bus_go;
      if (bus_go) begin
        dat_q <= rd;
      end
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = {24'h000000, dat_q};
  assign port_a_out = lat_a_q;
  assign port_a_oe = ~dir_a_q;
  assign port_e_out = lat_e_q;
  assign port_e_oe = ~dir_e_q;
  assign timer_clear = timer_clear_q;
  assign wake_req = wake_q;
  // The channel goes to the front end regardless of direction bits.
  assign afe.channel = ch_q;
  assign afe.powered = on_q && !down_q;
  assign afe.sample = (state_q == ST_ACQ);
  assign afe.trial = trial_q;

endmodule

// [sac_pkg.sv]
package sac_pkg;

  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned RC_PERIOD_NS = 4000;
  localparam int unsigned RC_HALF_CYC = (RC_PERIOD_NS / 2) / CLK_PERIOD_NS;
  localparam int unsigned INST_CYC = 4;
  localparam logic [4:0] HC_DONE = 5'h12;
  localparam logic [2:0] HOLD_HALVES = 3'h4;
  localparam logic [7:0] SAR_MSB = 8'h80;

  localparam logic [7:0] IDX_PORT_A = 8'h05;
  localparam logic [7:0] IDX_PORT_E = 8'h09;
  localparam logic [7:0] IDX_INTCTL = 8'h0B;
  localparam logic [7:0] IDX_INTCTL_HI = 8'h8B;
  localparam logic [7:0] IDX_PFLAG1 = 8'h0C;
  localparam logic [7:0] IDX_PFLAG2 = 8'h0D;
  localparam logic [7:0] IDX_RESULT = 8'h1E;
  localparam logic [7:0] IDX_CTRL = 8'h1F;
  localparam logic [7:0] IDX_DIR_A = 8'h85;
  localparam logic [7:0] IDX_DIR_E = 8'h89;
  localparam logic [7:0] IDX_PEN1 = 8'h8C;
  localparam logic [7:0] IDX_PEN2 = 8'h8D;
  localparam logic [7:0] IDX_PINCFG = 8'h9F;

  localparam int unsigned CTRL_ON = 0;
  localparam int unsigned CTRL_GO = 2;
  localparam int unsigned CTRL_CH_LO = 3;
  localparam int unsigned CTRL_CS_LO = 6;
  localparam int unsigned DONE_BIT = 6;

  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [2:0] PINCFG_RST = 3'h0;
  localparam logic [5:0] DIR_A_RST = 6'h3F;
  localparam logic [7:0] DIR_E_RST = 8'h07;
  localparam logic [7:0] RESULT_POR = 8'h00;

  localparam logic [1:0] CS_DIV2 = 2'h0;
  localparam logic [1:0] CS_DIV8 = 2'h1;
  localparam logic [1:0] CS_DIV32 = 2'h2;
  localparam logic [1:0] CS_RC = 2'h3;
  localparam logic [3:0] CMP_MODE_TRIG = 4'hB;

  typedef enum logic [2:0] {ST_OFF, ST_ACQ, ST_DELAY, ST_CONV, ST_HOLD} sac_state_t;

  typedef struct packed {
    logic powered;
    logic sample;
    logic [2:0] channel;
    logic [7:0] trial;
  } sac_afe_t;

endpackage

// [tb_top.sv]
`timescale 1ns/10ps
module tb_top;
  import sac_pkg::*;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic por_event = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [9:0] wb_adr_i = 10'h000;
  logic [31:0] wb_dat_i = 32'h00000000;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic [5:0] port_a_in = 6'h3F;
  logic [2:0] port_e_in = 3'h7;
  logic [5:0] port_a_oe;
  logic [5:0] port_a_out;
  logic [2:0] port_e_out;
  logic [2:0] port_e_oe;
  logic vref_from_pin;
  logic sleep_active = 1'b0;
  logic cmp_above;
  logic [3:0] ccp_mode = 4'h0;
  logic ccp_event = 1'b0;
  sac_afe_t afe;
  logic timer_clear;
  logic wake_req;
  int wakes = 0;
  int errors = 0;
  int checked = 0;
  int cycles = 0;
  sac_ctrl sac_ctrl_inst (.core_clk, .reset_n, .por_event, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i(4'h1), .wb_dat_i, .wb_dat_o, .wb_ack_o, .port_a_in, .port_a_out, .port_a_oe, .port_e_in,
    .port_e_out, .port_e_oe, .vref_from_pin, .sleep_active, .cmp_above, .ccp_mode, .ccp_event,
    .afe, .timer_clear, .wake_req);
  sac_afe_model sac_afe_model_inst (.core_clk, .afe, .cmp_above);
  always #4 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cycles++;
    if (wake_req === 1'b1) begin
      wakes++;
    end
    if (cycles == 50000) begin
      errors++;
      complete_run();
    end
  end
  task automatic complete_run();
    $display("Checks %0d, mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic [7:0] idx, input logic we, input logic [7:0] d, output logic [7:0] q);
    @(posedge core_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= {idx, 2'h0};
    wb_dat_i <= {24'h000000, d};
    do @(posedge core_clk); while (wb_ack_o !== 1'b1);
    q = wb_dat_o[7:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [7:0] q;
    wb(idx, 1'b1, d, q);
  endtask
  task automatic rc(input logic [7:0] idx, input logic [7:0] exp);
    logic [7:0] q;
    wb(idx, 1'b0, 8'h00, q);
    chk(q, exp);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic do_reset(input logic por);
    @(posedge core_clk);
    por_event <= por;
    reset_n <= 1'b0;
    tick(4);
    reset_n <= 1'b1;
  endtask
  function automatic int hp(input logic [1:0] cs);
    return (cs == CS_RC) ? RC_HALF_CYC : (cs == CS_DIV2) ? 1 : (cs == CS_DIV8) ? 4 : 16;
  endfunction
  task automatic conv(input logic [1:0] cs, input logic [2:0] ch);
    logic [7:0] q;
    time t0;
    int e;
    e = 19 * hp(cs) + ((cs == CS_RC) ? INST_CYC : 0);
    wr(IDX_CTRL, {cs, ch, 3'h1});
    tick(8 * hp(cs) + 4);
    wr(IDX_CTRL, {cs, ch, 3'h5});
    t0 = $time;
    do wb(IDX_CTRL, 1'b0, 8'h00, q); while (q[2] !== 1'b0);
    chk({7'h00, (($time - t0) / 8) inside {[e - 1 : e + 4]}}, 8'h01);
    rc(IDX_RESULT, {ch, 4'h5, ch[0]});
    rc(IDX_PFLAG1, 8'h40);
    wr(IDX_PFLAG1, 8'h00);
  endtask
  task automatic t_reset();
    logic [7:0] idx [8] = '{IDX_CTRL, IDX_PINCFG, IDX_DIR_A, IDX_DIR_E, IDX_RESULT, IDX_PFLAG1, IDX_PEN1, 8'h00};
    logic [7:0] exp [8] = '{8'h00, 8'h00, 8'h3F, 8'h07, RESULT_POR, 8'h00, 8'h00, 8'h00};
    for (int i = 0; i < 8; i++) begin
      rc(idx[i], exp[i]);
    end
    $display("reset test done");
  endtask
  task automatic t_port();
    logic [2:0] cfg [3] = '{3'h0, 3'h4, 3'h6};
    logic [7:0] ea [3] = '{8'h10, 8'h34, 8'h3F};
    logic [7:0] ee [3] = '{8'h00, 8'h07, 8'h07};
    for (int i = 0; i < 3; i++) begin
      wr(IDX_PINCFG, {5'h00, cfg[i]});
      rc(IDX_PORT_A, ea[i]);
      rc(IDX_PORT_E, ee[i]);
    end
    wr(IDX_PINCFG, 8'h05);
    chk({7'h00, vref_from_pin}, 8'h01);
    wr(IDX_PINCFG, 8'h06);
    chk({7'h00, vref_from_pin}, 8'h00);
    wr(IDX_PORT_A, 8'h2A);
    wr(IDX_DIR_A, 8'h0F);
    wr(IDX_PORT_E, 8'h03);
    wr(IDX_DIR_E, 8'h05);
    chk({2'h0, port_a_out}, 8'h2A);
    chk({2'h0, port_a_oe}, 8'h30);
    chk({5'h00, port_e_out}, 8'h03);
    chk({5'h00, port_e_oe}, 8'h02);
    wr(IDX_PINCFG, 8'h00);
    $display("port test done");
  endtask
  task automatic t_conv();
    for (int i = 0; i < 9; i++) begin
      conv((i == 8) ? CS_RC : 2'(i % 3), 3'(i));
    end
    $display("conversion test done");
  endtask
  task automatic t_abort();
    wr(IDX_RESULT, 8'h5A);
    wr(IDX_CTRL, 8'h99);
    tick(140);
    wr(IDX_CTRL, 8'h9D);
    tick(60);
    wr(IDX_CTRL, 8'h99);
    tick(56);
    chk({7'h00, afe.sample}, 8'h00);
    tick(16);
    chk({7'h00, afe.sample}, 8'h01);
    tick(250);
    rc(IDX_RESULT, 8'h5A);
    rc(IDX_PFLAG1, 8'h00);
    conv(CS_DIV32, 3'h3);
    $display("abort test done");
  endtask
  task automatic pulse(input logic [3:0] m, input logic exp);
    @(posedge core_clk);
    ccp_mode <= m;
    ccp_event <= 1'b1;
    @(posedge core_clk);
    ccp_event <= 1'b0;
    @(posedge core_clk);
    chk({7'h00, timer_clear}, {7'h00, exp});
  endtask
  task automatic t_trigger();
    wr(IDX_CTRL, 8'h29);
    tick(20);
    pulse(CMP_MODE_TRIG, 1'b1);
    tick(30);
    rc(IDX_CTRL, 8'h29);
    rc(IDX_RESULT, 8'hAB);
    wr(IDX_PFLAG1, 8'h00);
    pulse(4'hA, 1'b0);
    wr(IDX_CTRL, 8'h28);
    pulse(CMP_MODE_TRIG, 1'b1);
    wr(IDX_CTRL, 8'h2C);
    tick(60);
    rc(IDX_PFLAG1, 8'h00);
    chk({7'h00, afe.powered}, 8'h00);
    $display("trigger test done");
  endtask
  task automatic t_sleep();
    logic [7:0] q;
    int w0;
    wr(IDX_CTRL, 8'h51);
    tick(40);
    wr(IDX_CTRL, 8'h55);
    tick(20);
    sleep_active <= 1'b1;
    tick(10);
    chk({7'h00, afe.powered}, 8'h00);
    wb(IDX_CTRL, 1'b0, 8'h00, q);
    chk({7'h00, q[0]}, 8'h01);
    sleep_active <= 1'b0;
    tick(100);
    rc(IDX_PFLAG1, 8'h00);
    for (int en = 1; en >= 0; en--) begin
      wr(IDX_PEN1, en ? 8'h40 : 8'h00);
      w0 = wakes;
      wr(IDX_CTRL, 8'hF1);
      tick(2000);
      wr(IDX_CTRL, 8'hF5);
      sleep_active <= 1'b1;
      tick(5000);
      chk(8'(wakes - w0), 8'(en));
      if (en == 0) chk({7'h00, afe.powered}, 8'h00);
      sleep_active <= 1'b0;
      rc(IDX_RESULT, 8'hCA);
      wr(IDX_PFLAG1, 8'h00);
    end
    $display("sleep test done");
  endtask
  task automatic t_rerst();
    wr(IDX_PINCFG, 8'h06);
    do_reset(1'b0);
    rc(IDX_RESULT, 8'hCA);
    rc(IDX_CTRL, 8'h00);
    rc(IDX_PINCFG, 8'h00);
    $display("second reset test done");
  endtask
  initial begin
    do_reset(1'b1);
    t_reset();
    t_port();
    t_conv();
    t_abort();
    t_trigger();
    t_sleep();
    t_rerst();
    complete_run();
  end
endmodule
